// ===== design/liu_pkg.sv
// Shared constants and types for the line interface loss/jitter/loop block
package liu_pkg;

  // ----------------------------------------------------------------
  // Loss criteria, all figures in line bit periods
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 12;
  localparam logic [11:0] T1_NO_PULSE_BITS = 12'h0AF;
  localparam logic [11:0] T1_NO_PULSE_TOL = 12'h04B;
  localparam logic [11:0] T1_ZSUB_ZEROS = 12'h008;
  localparam logic [11:0] T1_MAX_ZEROS = 12'h064;
  localparam logic [11:0] LEVEL_WINDOW_BITS = 12'h0C0;
  localparam logic [11:0] EXIT_MIN_ONES = 12'h018;
  localparam logic [11:0] G775_NO_PULSE_BITS = 12'h0C0;
  localparam logic [11:0] G775_MIN_BITS = 12'h00A;
  localparam logic [11:0] G775_MAX_BITS = 12'h0FF;
  localparam logic [11:0] ETSI_NO_PULSE_BITS = 12'h800;

  // ----------------------------------------------------------------
  // Jitter buffer
  // ----------------------------------------------------------------
  localparam int unsigned JB_DEPTH_SMALL = 32;
  localparam int unsigned JB_DEPTH_LARGE = 128;
  localparam logic [7:0] JB_LIMIT_MARGIN = 8'h08;
  localparam logic [15:0] JB_STEP_RESET = 16'h1000;
  localparam logic [1:0] JB_PATH_RX = 2'h1;
  localparam logic [1:0] JB_PATH_TX = 2'h2;

  // Reference ticks per bit while sending ones on loss
  localparam logic [7:0] MCLK_ONES_DIV = 8'h0D;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRIT_T1,
    CRIT_E1_G775,
    CRIT_E1_ETSI
  } loss_criteria_t;

  typedef struct packed {
    loss_criteria_t criteria;
    logic long_haul;
    logic zero_sub;
    logic jitter_buffer_depth_select;
    logic jitter_path_select_hi;
    logic jitter_path_select_lo;
    logic analog_loop;
    logic local_loop;
    logic remote_loop;
    logic all_ones_on_loss;
  } line_cfg_t;

  typedef struct packed {
    logic los;
    logic los_latched;
    logic jitter_limit_trip_latched;
  } line_latched_status_t;

endpackage

// ===== design/jitter_fifo.sv
// Bit-wide jitter buffer with a smoothed read strobe
`timescale 1ns/1ps
`default_nettype none
module jitter_fifo #(
  parameter int unsigned DEPTH = liu_pkg::JB_DEPTH_LARGE
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic deep_in,
  input wire logic wr_stb_in,
  input wire logic wr_bit_in,
  output logic rd_stb_out,
  output logic rd_bit_out,
  output logic near_limit_out
);
  import liu_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);

  logic [DEPTH-1:0] mem_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] fill_q;
  logic [15:0] step_q;
  logic [16:0] acc_q;
  logic running_q;
  logic rd_stb_q;
  logic rd_bit_q;
  logic [AW:0] depth;
  logic [AW:0] half;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;
  logic [AW-1:0] wrap;

  // Active depth follows the select bit
  assign depth = deep_in ? (AW+1)'(JB_DEPTH_LARGE) : (AW+1)'(JB_DEPTH_SMALL);
  assign half = depth >> 1;
  assign wrap = AW'(depth - 1'b1);
  assign full = (fill_q == depth);
  assign empty = (fill_q == '0);
  assign do_wr = wr_stb_in && !full;
  // Reads wait until the buffer is centred, then follow the smoothed rate
  assign do_rd = acc_q[16] && running_q && !empty;
  assign near_limit_out = running_q &&
    ((fill_q <= (AW+1)'(JB_LIMIT_MARGIN)) ||
     (fill_q >= depth - (AW+1)'(JB_LIMIT_MARGIN)));
  assign rd_stb_out = rd_stb_q;
  assign rd_bit_out = rd_bit_q;

  // Storage and pointers
  always_ff @(posedge ref_clk_in)
  begin
    if (do_wr)
      mem_q[wr_ptr_q] <= wr_bit_in;
    if (sys_rst_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
      rd_stb_q <= 1'b0;
      rd_bit_q <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_q <= (wr_ptr_q >= wrap) ? '0 : wr_ptr_q + 1'b1;
      if (do_rd)
        rd_ptr_q <= (rd_ptr_q >= wrap) ? '0 : rd_ptr_q + 1'b1;
      fill_q <= fill_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      rd_stb_q <= do_rd;
      rd_bit_q <= do_rd ? mem_q[rd_ptr_q] : rd_bit_q;
    end
  end

  // Smoothed clock: phase accumulator whose step leans on the fill level
  // Slow trimming keeps input jitter off the output rate
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      step_q <= JB_STEP_RESET;
      acc_q <= '0;
      running_q <= 1'b0;
    end
    else
    begin
      acc_q <= {1'b0, acc_q[15:0]} + {1'b0, step_q};
      if (fill_q >= half)
        running_q <= 1'b1;
      else if (empty)
        running_q <= 1'b0;
      if (wr_stb_in && fill_q > half && step_q != 16'hFFFF)
        step_q <= step_q + 16'h0001;
      else if (wr_stb_in && fill_q < half && step_q != 16'h0001)
        step_q <= step_q - 16'h0001;
    end
  end
endmodule // jitter_fifo
`default_nettype wire

// ===== design/liu_loss_jitter_loopback.sv
// Line interface digital port: loss detection, jitter buffer, loopbacks
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: T1 loss after 175 +/-75 pulse-free bits
// RQ2: T1 exit at one-eighth ones density
// RQ3: T1 exit blocked by 8/100 zero runs
// RQ4: G775 loss and exit within 10-255 bits
// RQ5: ETSI loss after 2048 pulse-free bits
// RQ6: T1 short haul low level 192 bits
// RQ7: T1 short haul exit 24 ones/192
// RQ8: T1 long haul low level 192 bits
// RQ9: T1 long haul exit 24 ones/192
// RQ10: E1 G775 short haul 192/192 bits
// RQ11: E1 ETSI short haul 2048 in, 192 out
// RQ12: E1 ETSI long haul 192 in, 192 out
// RQ13: Buffer depth 32 or 128 by bit
// RQ14: Buffer in receive, transmit or off
// RQ15: Smoothed read clock, gapped transmit clock ok
// RQ16: Latched flag within 8 of limits
// RQ17: Reference clock is a line-rate multiple
// RQ18: Analog, local, remote loops; remote+local allowed
// RQ19: Analog loop receives own transmit output
// RQ20: Local loop returns transmit backplane data
// RQ21: Remote loop sends received data out
// RQ22: All ones on loss, reference timed
// RQ23: Live and latched loss status
module liu_loss_jitter_loopback (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire liu_pkg::line_cfg_t cfg_in,
  input wire logic status_clear_in,
  input wire logic receive_line_pos_in,
  input wire logic receive_line_neg_in,
  input wire logic recovered_clock_in,
  input wire logic below_loss_level_in,
  input wire logic above_exit_level_in,
  input wire logic transmit_line_clock_in,
  input wire logic tx_backplane_data_in,
  output logic transmit_line_pos_out,
  output logic transmit_line_neg_out,
  output logic tx_line_strobe_out,
  output logic rx_backplane_data_out,
  output logic rx_backplane_strobe_out,
  output liu_pkg::line_latched_status_t line_latched_status_out
);
  import liu_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 7;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic rx_clk_d1_q, tx_clk_d1_q;

  assign pins = {receive_line_pos_in, receive_line_neg_in,
                 recovered_clock_in, below_loss_level_in,
                 above_exit_level_in, transmit_line_clock_in,
                 tx_backplane_data_in};

  // Two stages; only the second stage feeds logic
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      rx_clk_d1_q <= 1'b0;
      tx_clk_d1_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      rx_clk_d1_q <= sync2_q[4];
      tx_clk_d1_q <= sync2_q[1];
    end
  end

  logic pin_pos, pin_neg, pin_below, pin_above, pin_tx_data;
  logic rx_clk_rise, tx_clk_rise;

  assign pin_pos = sync2_q[6];
  assign pin_neg = sync2_q[5];
  assign pin_below = sync2_q[3];
  assign pin_above = sync2_q[2];
  assign pin_tx_data = sync2_q[0];
  assign rx_clk_rise = sync2_q[4] && !rx_clk_d1_q;
  // Gapped framer clock simply yields fewer strobes
  assign tx_clk_rise = sync2_q[1] && !tx_clk_d1_q; // see RQ15

  // ----------------------------------------------------------------
  // Receive front end and analog loop
  // ----------------------------------------------------------------
  logic tx_pos_q, tx_neg_q, tx_stb_q;
  logic rx_stb, rx_bit, lvl_below, lvl_above;

  // External receive pins ignored while in analog loop
  assign rx_stb = cfg_in.analog_loop ? tx_stb_q : rx_clk_rise; // see RQ19
  assign rx_bit = cfg_in.analog_loop ? (tx_pos_q | tx_neg_q)
                                     : (pin_pos | pin_neg); // see RQ19
  assign lvl_below = cfg_in.analog_loop ? 1'b0 : pin_below;
  assign lvl_above = cfg_in.analog_loop ? 1'b1 : pin_above;

  // ----------------------------------------------------------------
  // Loss of signal
  // ----------------------------------------------------------------
  logic [11:0] zero_run_q, low_run_q, high_run_q, win_cnt_q, win_ones_q;
  logic win_long_zero_q, win_eight_zero_q, los_q, los_lat_q;
  logic [11:0] zero_run_d, low_run_d, high_run_d;
  logic win_end, win_ok, enter_t1, enter_g775, enter_etsi, enter_loss;
  logic exit_e1, exit_loss, zsub_block;

  // Saturating run counters, one tick per received bit
  assign zero_run_d = rx_bit ? '0
    : (zero_run_q == 12'hFFF ? zero_run_q : zero_run_q + 12'd1);
  assign low_run_d = !lvl_below ? '0
    : (low_run_q == 12'hFFF ? low_run_q : low_run_q + 12'd1);
  assign high_run_d = !(lvl_above && !lvl_below) ? '0
    : (high_run_q == 12'hFFF ? high_run_q : high_run_q + 12'd1);

  // T1: pulse-free span, or level below detection for the window
  assign enter_t1 = (zero_run_d >= T1_NO_PULSE_BITS) // see RQ1
    || (low_run_d >= LEVEL_WINDOW_BITS); // see RQ6 see RQ8
  // G775 span lies inside the 10-255 bit band
  assign enter_g775 = (zero_run_d >= G775_NO_PULSE_BITS) // see RQ4
    || (low_run_d >= LEVEL_WINDOW_BITS); // see RQ10
  // ETSI: long haul uses the shorter level window
  assign enter_etsi = (zero_run_d >= ETSI_NO_PULSE_BITS) // see RQ5
    || (low_run_d >= (cfg_in.long_haul ? LEVEL_WINDOW_BITS
                                       : ETSI_NO_PULSE_BITS)); // see RQ11
  assign enter_loss = (cfg_in.criteria == CRIT_T1) ? enter_t1
    : (cfg_in.criteria == CRIT_E1_G775) ? enter_g775 : enter_etsi;

  // T1 exit window: 192 bits, inside 175 +/-75
  assign win_end = (win_cnt_q == LEVEL_WINDOW_BITS - 12'd1);
  assign zsub_block = cfg_in.zero_sub && (win_eight_zero_q
    || zero_run_d >= T1_ZSUB_ZEROS); // see RQ3
  assign win_ok = (win_ones_q + 12'(rx_bit && lvl_above)
                   >= EXIT_MIN_ONES) // see RQ2 see RQ7 see RQ9
    && !win_long_zero_q && !(zero_run_d >= T1_MAX_ZEROS) // see RQ3
    && !zsub_block;
  // E1 exit after 192 bits above the exit level
  assign exit_e1 = (high_run_d >= LEVEL_WINDOW_BITS); // see RQ10 see RQ12
  assign exit_loss = (cfg_in.criteria == CRIT_T1) ? (win_end && win_ok)
                                                  : exit_e1; // see RQ11

  // Run counters and exit window, advanced on receive strobes
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      zero_run_q <= '0;
      low_run_q <= '0;
      high_run_q <= '0;
      win_cnt_q <= '0;
      win_ones_q <= '0;
      win_long_zero_q <= 1'b0;
      win_eight_zero_q <= 1'b0;
    end
    else if (rx_stb)
    begin
      zero_run_q <= zero_run_d;
      low_run_q <= low_run_d;
      high_run_q <= high_run_d;
      win_cnt_q <= win_end ? '0 : win_cnt_q + 12'd1;
      win_ones_q <= win_end ? '0
        : win_ones_q + 12'(rx_bit && lvl_above);
      win_long_zero_q <= !win_end &&
        (win_long_zero_q || zero_run_d >= T1_MAX_ZEROS);
      win_eight_zero_q <= !win_end &&
        (win_eight_zero_q || zero_run_d >= T1_ZSUB_ZEROS);
    end
  end

  // Loss state; the latched copy's set beats a same-cycle clear
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      los_q <= 1'b0;
      los_lat_q <= 1'b0;
    end
    else
    begin
      if (rx_stb && !los_q && enter_loss)
        los_q <= 1'b1;
      else if (rx_stb && los_q && exit_loss)
        los_q <= 1'b0;
      if (rx_stb && !los_q && enter_loss)
        los_lat_q <= 1'b1; // see RQ23
      else if (status_clear_in)
        los_lat_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Jitter buffer placement
  // ----------------------------------------------------------------
  logic [1:0] path_sel;
  logic ja_rx;
  logic ja_tx;
  logic src_stb;
  logic src_bit;
  logic fifo_wr_stb;
  logic fifo_wr_bit;
  logic fifo_rd_stb;
  logic fifo_rd_bit;
  logic fifo_near;
  logic rxp_stb;
  logic rxp_bit;
  logic jlt_lat_q;

  assign path_sel = {cfg_in.jitter_path_select_hi,
                     cfg_in.jitter_path_select_lo};
  // Other two codes leave the buffer out of both paths
  assign ja_rx = (path_sel == JB_PATH_RX); // see RQ14
  assign ja_tx = (path_sel == JB_PATH_TX); // see RQ14

  // Remote loop swaps framer data for recovered data
  assign src_stb = cfg_in.remote_loop ? rxp_stb : tx_clk_rise; // see RQ21
  assign src_bit = cfg_in.remote_loop ? rxp_bit : pin_tx_data; // see RQ21

  assign fifo_wr_stb = ja_rx ? rx_stb : (ja_tx ? src_stb : 1'b0);
  assign fifo_wr_bit = ja_rx ? rx_bit : src_bit;
  assign rxp_stb = ja_rx ? fifo_rd_stb : rx_stb;
  assign rxp_bit = ja_rx ? fifo_rd_bit : rx_bit;

  // Depth switch is meant for idle reconfiguration only
  jitter_fifo #(
    .DEPTH(JB_DEPTH_LARGE)
  ) u_jitter_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .deep_in(cfg_in.jitter_buffer_depth_select), // see RQ13
    .wr_stb_in(fifo_wr_stb),
    .wr_bit_in(fifo_wr_bit),
    .rd_stb_out(fifo_rd_stb), // see RQ15
    .rd_bit_out(fifo_rd_bit),
    .near_limit_out(fifo_near)
  );

  // Limit trip is sticky; set wins over clear
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      jlt_lat_q <= 1'b0;
    else if ((ja_rx || ja_tx) && fifo_near)
      jlt_lat_q <= 1'b1; // see RQ16
    else if (status_clear_in)
      jlt_lat_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transmit line and all-ones generator
  // ----------------------------------------------------------------
  logic [7:0] ones_div_q;
  logic ones_tick;
  logic send_ones;
  logic tx_stb;
  logic tx_bit;
  logic ami_pol_q;

  // Reference-clock divider so ones keep going with no framer clock
  assign ones_tick = (ones_div_q == MCLK_ONES_DIV - 8'd1);
  assign send_ones = cfg_in.all_ones_on_loss && los_q; // see RQ22
  assign tx_stb = send_ones ? ones_tick
    : (ja_tx ? fifo_rd_stb : src_stb); // see RQ22
  assign tx_bit = send_ones ? 1'b1 : (ja_tx ? fifo_rd_bit : src_bit);

  // Bipolar marks alternate polarity
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ones_div_q <= '0;
      ami_pol_q <= 1'b0;
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
      tx_stb_q <= 1'b0;
    end
    else
    begin
      ones_div_q <= ones_tick ? '0 : ones_div_q + 8'd1;
      tx_stb_q <= tx_stb;
      if (tx_stb)
      begin
        tx_pos_q <= tx_bit && !ami_pol_q;
        tx_neg_q <= tx_bit && ami_pol_q;
        ami_pol_q <= ami_pol_q ^ tx_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive backplane and local loop
  // ----------------------------------------------------------------
  logic rbp_bit_q;
  logic rbp_stb_q;

  // Local loop returns framer data; the line gets it too unless remote loop is also on
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      rbp_bit_q <= 1'b0;
      rbp_stb_q <= 1'b0;
    end
    else if (cfg_in.local_loop)
    begin
      rbp_stb_q <= tx_clk_rise; // see RQ20 see RQ18
      rbp_bit_q <= tx_clk_rise ? pin_tx_data : rbp_bit_q; // see RQ20
    end
    else
    begin
      rbp_stb_q <= rxp_stb;
      rbp_bit_q <= rxp_stb ? rxp_bit : rbp_bit_q;
    end
  end

  assign transmit_line_pos_out = tx_pos_q;
  assign transmit_line_neg_out = tx_neg_q;
  assign tx_line_strobe_out = tx_stb_q;
  assign rx_backplane_data_out = rbp_bit_q;
  assign rx_backplane_strobe_out = rbp_stb_q;
  assign line_latched_status_out =
    line_latched_status_t'({los_q, los_lat_q, jlt_lat_q}); // see RQ23
endmodule // liu_loss_jitter_loopback
`default_nettype wire

// ===== sim/liu_line_model.sv
// Line and framer stand-in: receive pins, recovered and framer clocks
`timescale 1ns/1ps
`default_nettype none
module liu_line_model (
  output logic rx_pos_out,
  output logic rx_neg_out,
  output logic rx_clk_out,
  output logic tx_clk_out,
  output logic tx_data_out,
  input wire logic ref_clk_in
);
  logic pol_q = 1'b0;
  // ------------------------------
  // Bit tasks, entered and left 2 ns after an edge
  // ------------------------------
  initial
  begin
    {rx_pos_out, rx_neg_out, rx_clk_out} = 3'h0;
    {tx_clk_out, tx_data_out} = 2'h0;
  end
  // Received bit; marks alternate polarity as on a real line
  task automatic rx_bit(input logic m);
    rx_pos_out = m & ~pol_q;
    rx_neg_out = m & pol_q;
    pol_q = pol_q ^ m;
    pulse(1'b0);
  endtask
  // Framer bit; its clock only runs while bits are offered
  task automatic tx_bit(input logic d);
    tx_data_out = d;
    pulse(1'b1);
  endtask
  // Four cycles high, four low, so the synchroniser sees each level
  task automatic pulse(input logic tx);
    if (tx) tx_clk_out = 1'b1;
    else rx_clk_out = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #2;
    if (tx) tx_clk_out = 1'b0;
    else rx_clk_out = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #2;
  endtask
endmodule // liu_line_model
`default_nettype wire

// ===== sim/liu_loss_jitter_loopback_props.sv
// Assertions on the loss flags, loop paths and buffer flag
`timescale 1ns/1ps
`default_nettype none
module liu_loss_jitter_loopback_props (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire liu_pkg::line_cfg_t cfg_in,
  input wire logic status_clear_in,
  input wire logic transmit_line_pos_out,
  input wire logic transmit_line_neg_out,
  input wire logic tx_line_strobe_out,
  input wire logic rx_backplane_data_out,
  input wire logic rx_backplane_strobe_out,
  input wire liu_pkg::line_latched_status_t line_latched_status_out
);
  import liu_pkg::*;
  // Shorthands; loop checks only hold with the buffer out of the way
  wire logic los = line_latched_status_out.los;
  wire logic lat = line_latched_status_out.los_latched;
  wire logic trip = line_latched_status_out.jitter_limit_trip_latched;
  wire logic mark = transmit_line_pos_out | transmit_line_neg_out;
  wire logic ones = cfg_in.all_ones_on_loss & los;
  wire logic nobuf = cfg_in.jitter_path_select_hi
    == cfg_in.jitter_path_select_lo;
  wire logic loops = nobuf & ~ones & ~cfg_in.analog_loop;
  wire logic loc = loops & cfg_in.local_loop & ~cfg_in.remote_loop;
  wire logic rem = loops & cfg_in.remote_loop & ~cfg_in.local_loop;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ------------------------------
  // Properties
  // ------------------------------
  reset_idle_a:
    assert property (disable iff (1'b0) sys_rst_in |=> !los && !lat && !trip)
    else $error("status not cleared by reset");
  tx_pulse_a:
    assert property (tx_line_strobe_out |=> !tx_line_strobe_out)
    else $error("line strobe wider than one cycle");
  los_set_a:
    assert property ($rose(los) |-> ##[0:1] lat)
    else $error("loss entry not latched");
  los_hold_a:
    assert property (lat && !status_clear_in |=> lat)
    else $error("latched loss dropped without clear");
  trip_hold_a:
    assert property (trip && !status_clear_in |=> trip)
    else $error("latched trip dropped without clear");
  ones_rate_a:
    assert property (ones && nobuf && tx_line_strobe_out
      |-> mark ##[1:13] (tx_line_strobe_out || !ones))
    else $error("ones on loss not sent every 13 cycles");
  local_loop_a:
    assert property (loc && tx_line_strobe_out |-> ##[0:1]
      (rx_backplane_strobe_out && rx_backplane_data_out == mark))
    else $error("framer bit not returned to backplane");
  remote_loop_a:
    assert property (rem && rx_backplane_strobe_out |-> ##[0:1]
      (tx_line_strobe_out && mark == rx_backplane_data_out))
    else $error("received bit not sent back to line");
  los_entry_c: cover property ($rose(los));
  los_exit_c: cover property ($fell(los));
  trip_c: cover property ($rose(trip));
endmodule // liu_loss_jitter_loopback_props
bind liu_loss_jitter_loopback liu_loss_jitter_loopback_props i_props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg_in),
  .status_clear_in(status_clear_in),
  .transmit_line_pos_out(transmit_line_pos_out),
  .transmit_line_neg_out(transmit_line_neg_out),
  .tx_line_strobe_out(tx_line_strobe_out),
  .rx_backplane_data_out(rx_backplane_data_out),
  .rx_backplane_strobe_out(rx_backplane_strobe_out),
  .line_latched_status_out(line_latched_status_out));
`default_nettype wire

// ===== sim/liu_loss_jitter_loopback_tb.sv
// Self-checking bench for the loss, jitter buffer and loop block
`timescale 1ns/1ps
`default_nettype none
module liu_loss_jitter_loopback_tb;
  import liu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic blw = 1'b0;
  logic abv = 1'b1;
  line_cfg_t cfg = '0;
  logic rp, rn, rc, tc, td, tp, tn, ts, rd, rs;
  line_latched_status_t st;
  logic rx_q[$];
  logic tx_q[$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk; // Reference at 8x the modelled bit rate
  liu_line_model i_liu_line_model (.ref_clk_in(clk), .rx_pos_out(rp),
    .rx_neg_out(rn), .rx_clk_out(rc), .tx_clk_out(tc), .tx_data_out(td));
  liu_loss_jitter_loopback i_liu_loss_jitter_loopback (
    .ref_clk_in(clk), .sys_rst_in(rst), .cfg_in(cfg),
    .status_clear_in(clr), .receive_line_pos_in(rp),
    .receive_line_neg_in(rn), .recovered_clock_in(rc),
    .below_loss_level_in(blw), .above_exit_level_in(abv),
    .transmit_line_clock_in(tc), .tx_backplane_data_in(td),
    .transmit_line_pos_out(tp), .transmit_line_neg_out(tn),
    .tx_line_strobe_out(ts), .rx_backplane_data_out(rd),
    .rx_backplane_strobe_out(rs), .line_latched_status_out(st));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Config is static, so every change goes through a reset
  task automatic boot(input line_cfg_t c);
    cfg = c;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rx_q.delete();
    tx_q.delete();
  endtask
  // n bits of a repeating 12-bit pattern, line side or framer side
  task automatic send(input logic fr, input logic [11:0] p, input int n);
    for (int i = 0; i < n; i++)
      if (fr) i_liu_line_model.tx_bit(p[i % 12]);
      else i_liu_line_model.rx_bit(p[i % 12]);
  endtask
  // Up to 400 bits while loss holds; covers two exit windows
  task automatic leave(input logic [11:0] p);
    for (int i = 0; i < 400 && st.los === 1'b1; i++)
      i_liu_line_model.rx_bit(p[i % 12]);
  endtask
  task automatic cmpq(ref logic q[$], input logic [11:0] p, input int n);
    chk(q.size(), n);
    for (int i = 0; i < n && i < q.size(); i++)
      chk(q[i], p[i % 12]);
  endtask
  // Collect output bits; a cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (rs) rx_q.push_back(rd);
    if (ts) tx_q.push_back(tp | tn);
    if (cyc == 80000)
    begin
      err_count++;
      results();
    end
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    line_cfg_t c;
    logic [11:0] pa;
    c = '0;
    #2 boot(c);
    send(0, 12'hFFF, 10);
    send(0, 12'h000, 174);
    chk(st.los, 1'b0);
    send(0, 12'h000, 2);
    chk({st.los, st.los_latched}, 2'b11);
    leave(12'hFFF);
    chk({st.los, st.los_latched}, 2'b01);
    clr = 1'b1;
    repeat (2) @(posedge clk);
    #2 clr = 1'b0;
    chk(st.los_latched, 1'b0);
    // Runs of 8 zeros block exit only under zero substitution
    for (int z = 0; z < 2; z++)
    begin
      c.zero_sub = z[0];
      boot(c);
      send(0, 12'h000, 180);
      leave(12'h201);
      chk(st.los, z[0]);
    end
    // Low level entry and 192-bit exit: T1 in both hauls, G775 short haul, ETSI long haul
    for (int k = 0; k < 4; k++)
    begin
      c = '0;
      c.criteria = (k == 1) ? CRIT_E1_G775 : (k == 2) ? CRIT_E1_ETSI : CRIT_T1;
      c.long_haul = (k != 1) && (k != 3);
      boot(c);
      {blw, abv} = 2'b10;
      send(0, 12'hFFF, 189);
      chk(st.los, 1'b0);
      send(0, 12'hFFF, 5);
      chk(st.los, 1'b1);
      {blw, abv} = 2'b01;
      leave(12'hFFF);
      chk(st.los, 1'b0);
    end
    // Pulse-free spans per E1 set; ETSI short haul low level waits 2048
    for (int k = 0; k < 2; k++)
    begin
      c = '0;
      c.criteria = k ? CRIT_E1_ETSI : CRIT_E1_G775;
      boot(c);
      blw = k[0];
      send(0, 12'h000, k ? 2045 : 189);
      chk(st.los, 1'b0);
      send(0, 12'h000, 5);
      chk(st.los, 1'b1);
    end
    blw = 1'b0;
    c = '0;
    c.all_ones_on_loss = 1'b1;
    boot(c);
    send(0, 12'h000, 177);
    tx_q.delete();
    repeat (130) @(posedge clk);
    #2;
    chk(tx_q.size(), 16'd10);
    chk(tx_q.and(), 1'b1);
    // Loops: local, local with remote, analog, remote
    for (int k = 0; k < 4; k++)
    begin
      c = '0;
      c.local_loop = (k < 2);
      c.remote_loop = k[0];
      c.analog_loop = (k == 2);
      boot(c);
      fork
        send(0, 12'h3C5, 12);
        send(1, 12'hB5A, 12);
      join
      repeat (20) @(posedge clk);
      #2;
      pa = k[0] ? 12'h3C5 : 12'hB5A;
      cmpq(tx_q, pa, 12);
      pa = (k == 3) ? 12'h3C5 : 12'hB5A;
      cmpq(rx_q, pa, 12);
    end
    // Buffer holds output back until half full, in either path
    for (int k = 0; k < 3; k++)
    begin
      c = '0;
      c.jitter_buffer_depth_select = (k == 1);
      c.jitter_path_select_lo = (k < 2);
      c.jitter_path_select_hi = (k == 2);
      boot(c);
      send(k == 2, 12'hA5C, (k == 1) ? 63 : 15);
      chk(rx_q.size() + tx_q.size(), 16'd0);
    end
    // Faster writes than reads push the small buffer near full
    c = '0;
    c.jitter_path_select_lo = 1'b1;
    boot(c);
    send(0, 12'hA5C, 40);
    repeat (800) @(posedge clk);
    #2;
    cmpq(rx_q, 12'hA5C, 40);
    chk(st.jitter_limit_trip_latched, 1'b1);
    results();
  end
endmodule // liu_loss_jitter_loopback_tb
`default_nettype wire
